// *** autoneg_pkg.sv ***
/*
 * constants shared by the negotiation result resolver: register indices,
 * field positions, reset values and the resolved-mode enumeration.
 * assumes a 32-bit apb slave where byte address = 4 * register index.
 */
package autoneg_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] IDX_BASIC_CTL = 6'h00;
  localparam logic [5:0] IDX_LOCAL_ADV = 6'h04;
  localparam logic [5:0] IDX_PARTNER_ADV = 6'h05;
  localparam logic [5:0] IDX_RES_STATUS = 6'h11;
  localparam logic [5:0] IDX_CRITERIA = 6'h13;
  localparam logic [5:0] IDX_EXP_DATA = 6'h1d;
  localparam logic [5:0] IDX_EXP_PTR = 6'h1e;
  localparam logic [8:0] EXP_FALLBACK_LOC = 9'h1c0;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_NEG_EN = 12;
  localparam int BIT_FALLBACK_EN = 3;
  localparam int BIT_PAUSE = 10;
  localparam int BIT_ASYM_PAUSE = 11;
  localparam int BIT_100FD = 8;
  localparam int BIT_100HD = 7;
  localparam int BIT_10FD = 6;
  localparam int BIT_10HD = 5;
  localparam int CRIT_AN = 2;
  localparam int CRIT_CRC = 1;
  localparam int CRIT_IDLE = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] ADV_SELECTOR = 16'h0001;
  localparam logic [2:0] CRIT_RESET = 3'h0;
  localparam logic FALLBACK_RESET = 1'b0;
  localparam logic [2:0] RETRY_RELOAD = 3'h5;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_1000_FD,
    MODE_1000_HD,
    MODE_100_FD,
    MODE_100_HD,
    MODE_10_FD,
    MODE_10_HD
  } mode_e;

endpackage : autoneg_pkg

// *** autoneg_resolution_fallback_tb.sv ***
/*
 * self-checking bench for the negotiation resolver: apb master,
 * random ability exchanges, fallback and forced-link corner cases.
 * assumes a 50 MHz sys_clk and the link_partner model.
 */
`timescale 1ns/1ps
`default_nettype none

module autoneg_resolution_fallback_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic negEnStrap = 1'b1;
  logic duplexStrap = 1'b1;
  logic multiNodeStrap = 1'b0;
  logic [1:0] rateStrap = 2'h0;
  logic pageValid, done, gigFd, gigHd, multi, manual, manMaster;
  logic [15:0] page, localAdvert;
  logic [10:0] seed;
  logic [3:0] evt;
  logic [2:0] resolvedMode;
  logic resolvedValid, isMaster, msFault, pauseConsider, forceLink;
  logic gigBlocked, localGigFd, localMultiNode;
  int nFail = 0;
  int cmpCount = 0;
  int rndSeed = 32'h136b;
  logic [31:0] rd, adv, pg, ab;
  logic err;
  logic [2:0] m;

  always #10 sys_clk = ~sys_clk;

  autoneg_resolver #(.SEED_W(11)) i_autoneg_resolver (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .negEnStrap(negEnStrap),
    .duplexStrap(duplexStrap), .rateStrap(rateStrap),
    .multiNodeStrap(multiNodeStrap), .partnerPageValid(pageValid),
    .partnerPage(page), .partnerGigFd(gigFd), .partnerGigHd(gigHd),
    .partnerMultiNode(multi), .partnerManual(manual),
    .partnerManualMaster(manMaster), .partnerSeed(seed),
    .negComplete(done), .gigAttemptFail(evt[0]), .crcErrDrop(evt[1]),
    .idleErrDrop(evt[2]), .partnerDrop(evt[3]),
    .resolvedMode(resolvedMode), .resolvedValid(resolvedValid),
    .isMaster(isMaster), .msFault(msFault),
    .pauseConsider(pauseConsider), .forceLink(forceLink),
    .gigBlocked(gigBlocked), .localAdvert(localAdvert),
    .localGigFd(localGigFd), .localMultiNode(localMultiNode));

  link_partner #(.SEED_W(11)) i_link_partner (
    .sys_clk(sys_clk), .pageValid(pageValid), .page(page),
    .gigFd(gigFd), .gigHd(gigHd), .multi(multi), .manual(manual),
    .manMaster(manMaster), .seed(seed), .done(done), .evt(evt));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    cmpCount++;
    if (g !== e)
    begin
      nFail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [5:0] idx,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      nFail++;
      $display("ERROR apb ready expected 1 seen %b", pready);
      wrap_up();
    end
  endtask : apb

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic burst(input int k, input int n);
    repeat (n) i_link_partner.pulse(k);
    tick(2);
  endtask : burst

  // partner seed zero: the never-zero local seed must win the tie
  task automatic gig_up;
    i_link_partner.exchange(16'h01e1, 5'h18, 11'h000);
    tick(2);
    chk("gig mode", 1, resolvedMode);
    chk("seed master", 1, isMaster);
    chk("seed fault", 0, msFault);
  endtask : gig_up

  // local gigabit half always offered, full follows duplex strap (1)
  function automatic logic [2:0] exp_mode(input logic [15:0] c,
                                          input logic fd, hd);
    if (fd) return autoneg_pkg::MODE_1000_FD;
    if (hd) return autoneg_pkg::MODE_1000_HD;
    if (c[8]) return autoneg_pkg::MODE_100_FD;
    if (c[7]) return autoneg_pkg::MODE_100_HD;
    if (c[6]) return autoneg_pkg::MODE_10_FD;
    if (c[5]) return autoneg_pkg::MODE_10_HD;
    return autoneg_pkg::MODE_NONE;
  endfunction : exp_mode

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    tick(2);
    chk("advert", 32'h01e1, localAdvert);
    chk("gig fd", 1, localGigFd);
    chk("multi", 0, localMultiNode);
    apb(0, autoneg_pkg::IDX_CRITERIA, 0);
    chk("criteria", 0, rd);
    apb(1, autoneg_pkg::IDX_EXP_PTR, 32'h1c0);
    apb(0, autoneg_pkg::IDX_EXP_DATA, 0);
    chk("fallback", 0, rd);
    apb(0, 6'h3f, 0);
    chk("slverr", 1, err);
    repeat (12)
    begin
      adv = ($random(rndSeed) & 32'h0de0) | 32'h1;
      apb(1, autoneg_pkg::IDX_LOCAL_ADV, adv);
      tick(1);
      chk("advert", adv, localAdvert);
      pg = $random(rndSeed);
      ab = $random(rndSeed);
      i_link_partner.exchange(pg[15:0], ab[4:0], ab[15:5]);
      tick(2);
      m = exp_mode(adv[15:0] & pg[15:0], ab[4], ab[3]);
      chk("mode", m, resolvedMode);
      chk("valid", m != 0, resolvedValid);
      chk("pause", m == 1 || m == 3 || m == 5, pauseConsider);
      if ((m == 1 || m == 2) && (ab[1] || ab[2]))
        chk("master", ab[1] & !ab[0], isMaster);
      if (m != 1 && m != 2)
        chk("no role", 0, {isMaster, msFault});
      apb(0, autoneg_pkg::IDX_PARTNER_ADV, 0);
      chk("store", pg[15:0], rd);
    end
    apb(1, autoneg_pkg::IDX_BASIC_CTL, 0);
    i_link_partner.exchange(16'h01e1, 5'h18, 11'h005);
    tick(2);
    chk("off mode", 0, resolvedMode);
    chk("off valid", 0, resolvedValid);
    apb(1, autoneg_pkg::IDX_BASIC_CTL, 32'h1000);
    apb(1, autoneg_pkg::IDX_LOCAL_ADV, 32'h01e1);
    apb(1, autoneg_pkg::IDX_EXP_DATA, 32'h8);
    apb(0, autoneg_pkg::IDX_EXP_DATA, 0);
    chk("fallback", 8, rd);
    gig_up();
    burst(0, 5);
    chk("no trigger", 0, gigBlocked);
    apb(1, autoneg_pkg::IDX_CRITERIA, 7);
    burst(0, 4);
    burst(3, 1);
    burst(0, 4);
    chk("reload", 0, gigBlocked);
    burst(0, 1);
    chk("blocked", 1, gigBlocked);
    i_link_partner.exchange(16'h01e1, 5'h18, 11'h005);
    tick(2);
    chk("fallen", 3, resolvedMode);
    burst(1, 5);
    chk("stay", 3, resolvedMode);
    chk("no force", 0, forceLink);
    apb(1, autoneg_pkg::IDX_BASIC_CTL, 0);
    apb(1, autoneg_pkg::IDX_BASIC_CTL, 32'h1000);
    tick(1);
    chk("unblocked", 0, gigBlocked);
    gig_up();
    burst(1, 5);
    chk("crc fall", 1, gigBlocked);
    apb(1, autoneg_pkg::IDX_BASIC_CTL, 0);
    apb(1, autoneg_pkg::IDX_BASIC_CTL, 32'h1000);
    apb(1, autoneg_pkg::IDX_EXP_DATA, 0);
    apb(1, autoneg_pkg::IDX_CRITERIA, 1);
    gig_up();
    burst(1, 5);
    burst(0, 5);
    chk("crc off", 0, forceLink);
    burst(2, 4);
    chk("four", 0, forceLink);
    burst(2, 1);
    chk("forced", 1, forceLink);
    chk("forced mode", 1, resolvedMode);
    chk("no block", 0, gigBlocked);
    burst(3, 1);
    chk("released", 0, forceLink);
    wrap_up();
  end
endmodule : autoneg_resolution_fallback_tb
`default_nettype wire

// *** autoneg_resolver.sv ***
/*
 * negotiation result resolver: priority resolution, master/slave roles,
 * pause advertisement storage, gigabit fallback and retry forced link.
 * assumes synchronous strap and event inputs, apb master on sys_clk.
 */
// How it works
// [RULE_01] pick highest common mode, gigabit full first
// [RULE_02] straps set advertised speeds and duplex
// [RULE_03] fallback bit set enables speed fallback
// [RULE_04] three criteria bits choose fallback triggers
// [RULE_05] fallback only leaves gigabit, never 100 to 10
// [RULE_06] five failed gigabit attempts drop speed
// [RULE_07] five error-rate link drops drop speed
// [RULE_08] partner drop or unplug reloads count five
// [RULE_09] forced-link mode is the power-up default
// [RULE_10] software keeps failure bit zero in forced-link
// [RULE_11] five error drops force link at best speed
// [RULE_12] roles resolved only for gigabit, multiport wins
// [RULE_13] node strap advertises single or multi node
// [RULE_14] equal node types settled by random seeds
// [RULE_15] opposite of manual partner; multi beats single
// [RULE_16] advert bits 10 and 11 give pause
// [RULE_17] partner pause bits stored in 10, 11
// [RULE_18] mac reads partner pause and resolves itself
// [RULE_19] flow control considered only for full duplex
// [RULE_20] expanded byte reached by pointer and data
// [RULE_21] strap low or control bit 12 disables
// [RULE_22] counter counts down, action fires at zero
`timescale 1ns/1ps
`default_nettype none

module autoneg_resolver #(
  parameter int SEED_W = 11
) (
  input wire logic sys_clk, // system clock, 50 MHz
  input wire logic rstn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped or misaligned
  input wire logic negEnStrap, // negotiation enable strap
  input wire logic duplexStrap, // duplex strap
  input wire logic [1:0] rateStrap, // speed straps
  input wire logic multiNodeStrap, // node-type strap
  input wire logic partnerPageValid, // pulse: partner base page received
  input wire logic [15:0] partnerPage, // partner base page word
  input wire logic partnerGigFd, // partner advertises gigabit full
  input wire logic partnerGigHd, // partner advertises gigabit half
  input wire logic partnerMultiNode, // partner advertises multi node
  input wire logic partnerManual, // partner role set manually
  input wire logic partnerManualMaster, // manual partner role is master
  input wire logic [SEED_W-1:0] partnerSeed, // partner random seed
  input wire logic negComplete, // pulse: ability exchange complete
  input wire logic gigAttemptFail, // pulse: gigabit link not stable
  input wire logic crcErrDrop, // pulse: link drop on crc error rate
  input wire logic idleErrDrop, // pulse: link drop on idle error rate
  input wire logic partnerDrop, // pulse: partner dropped link or unplug
  output logic [2:0] resolvedMode, // autoneg_pkg::mode_e code
  output logic resolvedValid, // a common mode was found
  output logic isMaster, // gigabit master role
  output logic msFault, // equal seeds, roles unresolved
  output logic pauseConsider, // full duplex: flow control exchanged
  output logic forceLink, // link forced at best common speed
  output logic gigBlocked, // gigabit excluded after fallback
  output logic [15:0] localAdvert, // base page sent to the partner
  output logic localGigFd, // gigabit full advertised
  output logic localMultiNode // multi node advertised
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic strapsTaken;
    logic negEn;
    logic gigFdAdv;
    logic multiAdv;
    logic [15:0] advWord;
    logic [15:0] lpar;
    logic [2:0] crit;
    logic fbMode;
    logic [8:0] ptr;
    logic [2:0] retryCnt;
    logic gigBlocked;
    logic forceLink;
    autoneg_pkg::mode_e mode;
    logic resolvedValid;
    logic isMaster;
    logic msFault;
    logic pauseConsider;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s q;
  state_s d;
  logic [SEED_W-1:0] localSeed;

  seed_lfsr #(
    .SEED_W(SEED_W)
  ) u_seed (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .seed(localSeed)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic isGig(input autoneg_pkg::mode_e m);
    isGig = (m == autoneg_pkg::MODE_1000_FD) ||
            (m == autoneg_pkg::MODE_1000_HD);
  endfunction : isGig

  function automatic logic isFull(input autoneg_pkg::mode_e m);
    isFull = (m == autoneg_pkg::MODE_1000_FD) ||
             (m == autoneg_pkg::MODE_100_FD) ||
             (m == autoneg_pkg::MODE_10_FD);
  endfunction : isFull

  // abilities: [5] 1000fd [4] 1000hd [3] 100fd [2] 100hd [1] 10fd [0] 10hd
  function automatic autoneg_pkg::mode_e bestMode(input logic [5:0] c);
    if (c[5])
      bestMode = autoneg_pkg::MODE_1000_FD;
    else if (c[4])
      bestMode = autoneg_pkg::MODE_1000_HD;
    else if (c[3])
      bestMode = autoneg_pkg::MODE_100_FD;
    else if (c[2])
      bestMode = autoneg_pkg::MODE_100_HD;
    else if (c[1])
      bestMode = autoneg_pkg::MODE_10_FD;
    else if (c[0])
      bestMode = autoneg_pkg::MODE_10_HD;
    else
      bestMode = autoneg_pkg::MODE_NONE;
  endfunction : bestMode

  function automatic logic [3:0] advBits(input logic [15:0] w);
    advBits = {w[autoneg_pkg::BIT_100FD], w[autoneg_pkg::BIT_100HD],
               w[autoneg_pkg::BIT_10FD], w[autoneg_pkg::BIT_10HD]};
  endfunction : advBits

  logic [5:0] localAbil;
  logic [5:0] partnerAbil;
  logic [5:0] common;
  logic gigActive;
  logic anQual;
  logic errQual;
  logic qual;
  logic [5:0] regIdx;
  logic accEnd;
  logic mapped;

  assign localAbil = {q.gigFdAdv, 1'b1, advBits(q.advWord)};
  assign partnerAbil = {partnerGigFd, partnerGigHd, advBits(q.lpar)};
  // fallback masks gigabit so the next lower advertised speed wins
  assign common = localAbil & partnerAbil & {~q.gigBlocked, ~q.gigBlocked,
                  4'hf}; // see [RULE_03]
  assign gigActive = q.resolvedValid && isGig(q.mode); // see [RULE_05]
  // failed-attempt trigger acts in fallback mode only
  assign anQual = q.fbMode && q.crit[autoneg_pkg::CRIT_AN] &&
                  gigAttemptFail; // see [RULE_04] see [RULE_10]
  assign errQual = (q.crit[autoneg_pkg::CRIT_CRC] && crcErrDrop) ||
                   (q.crit[autoneg_pkg::CRIT_IDLE] && idleErrDrop);
  assign qual = gigActive && !q.forceLink && (anQual || errQual);
  assign regIdx = paddr[7:2];
  assign accEnd = psel && penable && q.pready;
  assign mapped = (paddr[1:0] == 2'b00) &&
                  (regIdx == autoneg_pkg::IDX_BASIC_CTL ||
                   regIdx == autoneg_pkg::IDX_LOCAL_ADV ||
                   regIdx == autoneg_pkg::IDX_PARTNER_ADV ||
                   regIdx == autoneg_pkg::IDX_RES_STATUS ||
                   regIdx == autoneg_pkg::IDX_CRITERIA ||
                   regIdx == autoneg_pkg::IDX_EXP_DATA ||
                   regIdx == autoneg_pkg::IDX_EXP_PTR);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    d = q;
    // straps caught in the first cycle after reset release
    if (!q.strapsTaken)
    begin
      d.strapsTaken = 1'b1;
      d.negEn = negEnStrap; // see [RULE_21]
      d.gigFdAdv = duplexStrap; // see [RULE_02]
      d.multiAdv = multiNodeStrap; // see [RULE_13]
      d.advWord = autoneg_pkg::ADV_SELECTOR;
      d.advWord[autoneg_pkg::BIT_100FD] = ~rateStrap[1] & duplexStrap;
      d.advWord[autoneg_pkg::BIT_100HD] = ~rateStrap[1]; // see [RULE_02]
      d.advWord[autoneg_pkg::BIT_10FD] = ~(rateStrap[1] ^ rateStrap[0]) &
                                         duplexStrap;
      d.advWord[autoneg_pkg::BIT_10HD] = ~(rateStrap[1] ^ rateStrap[0]);
    end

    if (partnerPageValid)
      d.lpar = partnerPage; // see [RULE_17]

    // retry counting; a partner drop outranks a same-cycle error event
    if (partnerDrop)
    begin
      d.retryCnt = autoneg_pkg::RETRY_RELOAD; // see [RULE_08]
      d.forceLink = 1'b0;
    end
    else if (qual)
    begin
      d.retryCnt = q.retryCnt - 3'h1; // see [RULE_22]
      if (q.retryCnt == 3'h1)
      begin
        d.retryCnt = autoneg_pkg::RETRY_RELOAD;
        if (q.fbMode)
          d.gigBlocked = 1'b1; // see [RULE_06] see [RULE_07]
        else
          d.forceLink = 1'b1; // see [RULE_11]
      end
    end

    // resolution at the end of each exchange
    if (negComplete)
    begin
      d.mode = q.negEn ? bestMode(common) : autoneg_pkg::MODE_NONE;
      d.resolvedValid = d.mode != autoneg_pkg::MODE_NONE; // see [RULE_01]
      d.isMaster = 1'b0;
      d.msFault = 1'b0;
      d.pauseConsider = d.resolvedValid && isFull(d.mode); // see [RULE_19]
      if (d.resolvedValid && isGig(d.mode)) // see [RULE_12]
      begin
        if (partnerManual)
          d.isMaster = !partnerManualMaster; // see [RULE_15]
        else if (q.multiAdv != partnerMultiNode)
          d.isMaster = q.multiAdv; // see [RULE_15]
        else if (localSeed == partnerSeed)
          d.msFault = 1'b1; // see [RULE_14]
        else
          d.isMaster = localSeed > partnerSeed; // see [RULE_14]
      end
    end

    // apb: one wait state, answer registered
    d.pready = psel && penable && !q.pready;
    d.pslverr = psel && penable && !q.pready && !mapped;
    d.prdata = 32'h0;
    if (psel && penable && !q.pready && !pwrite)
    begin
      case (regIdx)
        autoneg_pkg::IDX_BASIC_CTL:
          d.prdata[autoneg_pkg::BIT_NEG_EN] = q.negEn;
        autoneg_pkg::IDX_LOCAL_ADV:
          d.prdata[15:0] = q.advWord;
        autoneg_pkg::IDX_PARTNER_ADV:
          d.prdata[15:0] = q.lpar; // see [RULE_18]
        autoneg_pkg::IDX_RES_STATUS:
          d.prdata[11:0] = {q.retryCnt, q.forceLink, q.gigBlocked,
                            q.pauseConsider, q.msFault, q.isMaster,
                            q.resolvedValid, q.mode};
        autoneg_pkg::IDX_CRITERIA:
          d.prdata[2:0] = q.crit;
        autoneg_pkg::IDX_EXP_DATA:
          d.prdata[autoneg_pkg::BIT_FALLBACK_EN] =
            (q.ptr == autoneg_pkg::EXP_FALLBACK_LOC) && q.fbMode;
        autoneg_pkg::IDX_EXP_PTR:
          d.prdata[8:0] = q.ptr;
        default:
          d.prdata = 32'h0;
      endcase
      if (!mapped)
        d.prdata = 32'h0;
    end

    if (accEnd && pwrite && mapped)
    begin
      case (regIdx)
        autoneg_pkg::IDX_BASIC_CTL:
          d.negEn = pwdata[autoneg_pkg::BIT_NEG_EN]; // see [RULE_21]
        autoneg_pkg::IDX_LOCAL_ADV:
          d.advWord = pwdata[15:0]; // see [RULE_16]
        autoneg_pkg::IDX_CRITERIA:
          d.crit = pwdata[2:0]; // see [RULE_04]
        autoneg_pkg::IDX_EXP_DATA:
        begin
          // only bit 3 of the write data reaches the expanded location
          if (q.ptr == autoneg_pkg::EXP_FALLBACK_LOC)
            d.fbMode = pwdata[autoneg_pkg::BIT_FALLBACK_EN]; // see [RULE_20]
        end
        autoneg_pkg::IDX_EXP_PTR:
          d.ptr = pwdata[8:0]; // see [RULE_20]
        default:
          d.ptr = q.ptr;
      endcase
    end
    // disabling negotiation clears a pending fallback
    if (!d.negEn)
      d.gigBlocked = 1'b0;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.crit <= autoneg_pkg::CRIT_RESET;
      q.fbMode <= autoneg_pkg::FALLBACK_RESET; // see [RULE_09]
      q.retryCnt <= autoneg_pkg::RETRY_RELOAD;
      q.advWord <= autoneg_pkg::ADV_SELECTOR;
      q.mode <= autoneg_pkg::MODE_NONE;
    end
    else
      q <= d;
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign resolvedMode = q.mode;
  assign resolvedValid = q.resolvedValid;
  assign isMaster = q.isMaster;
  assign msFault = q.msFault;
  assign pauseConsider = q.pauseConsider;
  assign forceLink = q.forceLink;
  assign gigBlocked = q.gigBlocked;
  assign localAdvert = q.advWord;
  assign localGigFd = q.gigFdAdv;
  assign localMultiNode = q.multiAdv;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_lastRetry;
    qual && !partnerDrop && q.retryCnt == 3'h1;
  endsequence

  property p_fallback_fires;
    @(posedge sys_clk) disable iff (!rstn)
    s_lastRetry and q.fbMode |=> gigBlocked && q.retryCnt == 3'h5;
  endproperty
  a_fallback_fires: assert property (p_fallback_fires) // see [RULE_06]
    else $error("fallback did not fire on fifth event");

  property p_forced_fires;
    @(posedge sys_clk) disable iff (!rstn)
    s_lastRetry and !q.fbMode |=> forceLink && !gigBlocked;
  endproperty
  a_forced_fires: assert property (p_forced_fires) // see [RULE_11]
    else $error("forced link did not fire on fifth event");

  property p_reload;
    @(posedge sys_clk) disable iff (!rstn)
    partnerDrop |=> q.retryCnt == 3'h5 && !forceLink;
  endproperty
  a_reload: assert property (p_reload) // see [RULE_08]
    else $error("retry count not reloaded on partner drop");

  property p_forced_ignores_fail;
    @(posedge sys_clk) disable iff (!rstn)
    !q.fbMode && !partnerDrop && !crcErrDrop && !idleErrDrop
      |=> $stable(q.retryCnt);
  endproperty
  a_forced_ignores_fail: assert property (p_forced_ignores_fail) // see [RULE_10]
    else $error("retry count moved without an error drop");

  property p_no_gig_when_blocked;
    @(posedge sys_clk) disable iff (!rstn)
    negComplete && gigBlocked && !partnerDrop ##1 1'b1
      |-> !isGig(q.mode);
  endproperty
  a_no_gig_when_blocked: assert property (p_no_gig_when_blocked) // see [RULE_05]
    else $error("gigabit chosen after fallback");

  property p_top_priority;
    @(posedge sys_clk) disable iff (!rstn)
    negComplete && q.negEn && q.gigFdAdv && partnerGigFd && !gigBlocked
      |=> resolvedMode == 3'(autoneg_pkg::MODE_1000_FD);
  endproperty
  a_top_priority: assert property (p_top_priority) // see [RULE_01]
    else $error("gigabit full not chosen as common best");

  property p_roles_gig_only;
    @(posedge sys_clk) disable iff (!rstn)
    (isMaster || msFault) |-> resolvedValid && isGig(q.mode);
  endproperty
  a_roles_gig_only: assert property (p_roles_gig_only) // see [RULE_12]
    else $error("role resolved outside gigabit");

  property p_pause_full_only;
    @(posedge sys_clk) disable iff (!rstn)
    negComplete ##1 pauseConsider |-> isFull(q.mode);
  endproperty
  a_pause_full_only: assert property (p_pause_full_only) // see [RULE_19]
    else $error("flow control considered in half duplex");

  property p_default_forced_mode;
    @(posedge sys_clk) disable iff (!rstn)
    !q.strapsTaken |=> !q.fbMode && q.retryCnt == 3'h5;
  endproperty
  a_default_forced_mode: assert property (p_default_forced_mode) // see [RULE_09]
    else $error("fallback mode set after reset");

endmodule : autoneg_resolver

`default_nettype wire

// *** link_partner.sv ***
/*
 * behavioural link partner: sends one base page and its gigabit and
 * role abilities, then the completion strobe, and raises link events.
 * assumes the bench calls its tasks on sys_clk after reset release.
 */
`timescale 1ns/1ps
`default_nettype none

module link_partner #(
  parameter int SEED_W = 11
) (
  input wire logic sys_clk, // system clock
  output logic pageValid, // base page strobe
  output logic [15:0] page, // base page word
  output logic gigFd, // gigabit full ability
  output logic gigHd, // gigabit half ability
  output logic multi, // multi node advertised
  output logic manual, // role set manually
  output logic manMaster, // manual role is master
  output logic [SEED_W-1:0] seed, // random seed
  output logic done, // exchange complete strobe
  output logic [3:0] evt // fail, crc, idle, drop pulses
);
  initial
  begin
    pageValid = 1'b0;
    done = 1'b0;
    evt = 4'h0;
    page = 16'h0000;
    {gigFd, gigHd, multi, manual, manMaster} = 5'h00;
    seed = '0;
  end

  // ****************************************************************
  // ability exchange
  // ****************************************************************
  task automatic exchange(input logic [15:0] p, input logic [4:0] a,
                          input logic [SEED_W-1:0] s);
    @(posedge sys_clk);
    page <= p;
    pageValid <= 1'b1;
    {gigFd, gigHd, multi, manual, manMaster} <= a;
    seed <= s;
    @(posedge sys_clk);
    pageValid <= 1'b0;
    done <= 1'b1;
    @(posedge sys_clk);
    done <= 1'b0;
    // levels are only valid with the strobes: scramble them afterwards
    page <= ~p;
    {gigFd, gigHd, multi, manual, manMaster} <= ~a;
    seed <= ~s;
  endtask : exchange

  task automatic pulse(input int k);
    @(posedge sys_clk);
    evt[k] <= 1'b1;
    @(posedge sys_clk);
    evt <= 4'h0;
  endtask : pulse
endmodule : link_partner
`default_nettype wire

// *** seed_lfsr.sv ***
/*
 * free-running maximal-length lfsr giving the local random seed used to
 * break equal node-type ties.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module seed_lfsr #(
  parameter int SEED_W = 11
) (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // async reset, active low
  output logic [SEED_W-1:0] seed // current seed value
);

  typedef struct packed {
    logic [SEED_W-1:0] shift;
  } lfsr_s;

  lfsr_s q;
  lfsr_s d;

  // taps for 11 bits; never all-zero since reset seeds a one
  always_comb
  begin
    d = q;
    d.shift = {q.shift[SEED_W-2:0], q.shift[SEED_W-1] ^ q.shift[SEED_W-3]};
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      q <= '{shift: {{(SEED_W-1){1'b0}}, 1'b1}};
    else
      q <= d;
  end

  assign seed = q.shift;

endmodule : seed_lfsr

`default_nettype wire
